//--- common/serial_port_pkg.sv
// Package for the asynchronous serial transceiver: register map, fields, reset values, bus carriers.
// Assumes a 32-bit Avalon-MM register bus and one 20 MHz clock.
package serial_port_pkg;

   // ==========================================================================
   // Register offsets (byte addresses)
   localparam logic [5:0] OFF_FLAGS = 6'h00;
   localparam logic [5:0] OFF_ENABLES = 6'h04;
   localparam logic [5:0] OFF_PRIORITIES = 6'h08;
   localparam logic [5:0] OFF_RX_STATUS = 6'h0c;
   localparam logic [5:0] OFF_TX_HOLD = 6'h10;
   localparam logic [5:0] OFF_TX_STATUS = 6'h14;
   localparam logic [5:0] OFF_BAUD_DIV = 6'h18;
   localparam logic [5:0] OFF_RX_DATA = 6'h1c;

   // ==========================================================================
   // Flag, enable and priority bit positions
   localparam int BIT_RX_COMPLETE = 5;
   localparam int BIT_TX_EMPTY = 4;

   // Receive status/control bit positions
   localparam int BIT_SERIAL_ENABLE = 7;
   localparam int BIT_RX_NINE = 6;
   localparam int BIT_SINGLE_RX = 5;
   localparam int BIT_CONT_RX = 4;
   localparam int BIT_ADDR_DETECT = 3;
   localparam int BIT_FRAMING_ERR = 2;
   localparam int BIT_OVERRUN_ERR = 1;
   localparam int BIT_RX_NINTH = 0;

   // Transmit status/control bit positions
   localparam int BIT_CLOCK_SOURCE = 7;
   localparam int BIT_TX_NINE = 6;
   localparam int BIT_TX_ENABLE = 5;
   localparam int BIT_SYNC_SELECT = 4;
   localparam int BIT_HIGH_SPEED = 2;
   localparam int BIT_SHIFT_EMPTY = 1;
   localparam int BIT_TX_NINTH = 0;

   // ==========================================================================
   // Reset values and timing counts
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [1:0] LOW_SPEED_PRESCALE_LAST = 2'h3;
   localparam logic [3:0] SAMPLES_LAST = 4'hf;
   localparam logic [3:0] START_CHECK_SAMPLE = 4'h7;
   localparam logic [3:0] ASYNC_FRAME_BITS = 4'ha;
   localparam logic [3:0] SYNC_FRAME_BITS = 4'h8;

   // ==========================================================================
   // Bus carriers and control fields
   typedef struct packed {
      logic read;
      logic write;
      logic [5:0] address;
      logic [31:0] writedata;
   } av_req_t;

   typedef struct packed {
      logic serialPortEnable;
      logic nineBitReceiveEnable;
      logic singleReceiveEnable;
      logic continuousReceiveEnable;
      logic addressDetectEnable;
   } rx_ctrl_t;

   typedef struct packed {
      logic clockSourceSelect;
      logic nineBitTransmitEnable;
      logic transmitEnable;
      logic syncSelect;
      logic highSpeedBaudSelect;
      logic transmitNinthBit;
   } tx_ctrl_t;

   typedef enum logic [1:0] {
      RX_IDLE = 2'b00,
      RX_START = 2'b01,
      RX_DATA = 2'b10,
      RX_STOP = 2'b11
   } rx_state_t;

endpackage

//--- hw/async_serial_transceiver.sv
// Asynchronous serial transceiver: baud generator, transmitter, x16 receiver, register slave.
// Assumes an Avalon-MM master on the same clock and an external serial node on the pins.
//
// Overview of operation
// - Shift register reloads from holding buffer only after previous stop bit.
// - Buffer-to-shifter transfer takes one cycle, then sets transmit empty flag.
// - Transmit empty flag sets regardless of enable; writes to the flag register cannot clear it.
// - Flag is valid by second cycle after buffer write; do not poll earlier.
// - Read-only shift-register-empty bit shows idle shifter; raises no interrupt.
// - Transmit shift register is not reachable by software.
// - Setting transmit enable also sets transmit empty flag when the holding buffer is empty.
// - Ninth transmit bit is sent when nine-bit transmit enabled; load first.
// - Writing holding buffer starts transmission; transmit enable set beforehand.
// - Receive front end samples at x16 baud; main shifter advances per bit.
// - Completed character sets receive flag; interrupt only when enabled.
// - Receive status holds ninth bit and errors; read before data byte.
// - Received 8-bit byte is readable in receive data register.
// - Clearing continuous receive enable clears latched receive errors.
// - Continuous receive enable turns the asynchronous receiver on.
// - Nine-bit receive captures nine bits; address detect needs it.
// - With address detect, non-address characters are dropped silently.
// - Clock source select gives sync master; sync select gives sync operation.
// - Sync mode is transmit-only: the receiver is held idle while sync is selected.
// - Sync mode: transmit pin carries shift clock only as master, syncDataOut carries data.
// - Async frames are NRZ: start, eight or nine data bits, stop.
// - Data shift least significant bit first both directions.
// - Baud generator runs at x16 or x64 bit rate by high-speed select.
module async_serial_transceiver (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic clockEnable,
   input wire serial_port_pkg::av_req_t avReq,
   output logic [31:0] avReadData,
   output logic avWaitRequest,
   input wire logic receivePin,
   output logic transmitPin,
   output logic syncDataOut,
   output logic syncDataOe_n,
   output logic txIrqRequest,
   output logic rxIrqRequest
);

   // ==========================================================================
   // Declarations
   serial_port_pkg::rx_ctrl_t rxCtrl_reg;
   serial_port_pkg::tx_ctrl_t txCtrl_reg;
   serial_port_pkg::rx_state_t rxState_reg;
   logic [7:0] baudDivisor_reg;
   logic [7:0] baudCount_reg;
   logic [1:0] prescale_reg;
   logic [1:0] enables_reg;
   logic [1:0] priorities_reg;
   logic [7:0] holdData_reg;
   logic holdFull_reg;
   logic txEmptyFlag_reg;
   logic [10:0] shift_reg;
   logic [3:0] bitsLeft_reg;
   logic [3:0] txTick_reg;
   logic txBusy_reg;
   logic [1:0] rxPinSync_reg;
   logic [2:0] sampleHist_reg;
   logic [3:0] rxTick_reg;
   logic [3:0] rxBitCnt_reg;
   logic [8:0] rxShift_reg;
   logic [7:0] rxData_reg;
   logic rxNinth_reg;
   logic rxFull_reg;
   logic framingErr_reg;
   logic overrunErr_reg;
   logic wait_reg;
   logic [31:0] readData_reg;
   logic brgTick;
   logic sampleTick;
   logic busAccept;
   logic writeAccept;
   logic readAccept;
   logic syncMode;
   logic rxEnabled;
   logic txLoad;
   logic sampleBit;
   logic charDone;
   logic rxTake;
   logic [3:0] rxBitsWanted;

   // Register hit for a given offset
   function automatic logic hit(input logic [5:0] addr, input logic [5:0] off);
      hit = (addr == off);
   endfunction

   // Two of three majority vote
   function automatic logic majority(input logic [2:0] s);
      majority = (s[0] & s[1]) | (s[1] & s[2]) | (s[0] & s[2]);
   endfunction

   // ==========================================================================
   // Bus handshake
   assign busAccept = (avReq.read | avReq.write) & ~wait_reg;
   assign writeAccept = busAccept & avReq.write;
   assign readAccept = busAccept & avReq.read;

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         wait_reg <= 1'b1;
      end else if (clockEnable) begin
         wait_reg <= ~((avReq.read | avReq.write) & wait_reg);
      end
   end

   // Read data captured on the same edge that waitrequest drops
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         readData_reg <= serial_port_pkg::RST_WORD;
      end else if (clockEnable) begin
         readData_reg <= serial_port_pkg::RST_WORD;
         if (avReq.read & wait_reg) begin
            unique case (1'b1)
               hit(avReq.address, serial_port_pkg::OFF_FLAGS):
                  readData_reg[7:0] <= {2'b00, rxFull_reg, txEmptyFlag_reg, 4'h0};
               hit(avReq.address, serial_port_pkg::OFF_ENABLES):
                  readData_reg[7:0] <= {2'b00, enables_reg, 4'h0};
               hit(avReq.address, serial_port_pkg::OFF_PRIORITIES):
                  readData_reg[7:0] <= {2'b00, priorities_reg, 4'h0};
               hit(avReq.address, serial_port_pkg::OFF_RX_STATUS):
                  readData_reg[7:0] <= {rxCtrl_reg, framingErr_reg, overrunErr_reg, rxNinth_reg};
               hit(avReq.address, serial_port_pkg::OFF_TX_HOLD):
                  readData_reg[7:0] <= holdData_reg;
               hit(avReq.address, serial_port_pkg::OFF_TX_STATUS):
                  readData_reg[7:0] <= {txCtrl_reg[5:2], 1'b0, txCtrl_reg[1], ~txBusy_reg,
                                        txCtrl_reg[0]};
               hit(avReq.address, serial_port_pkg::OFF_BAUD_DIV):
                  readData_reg[7:0] <= baudDivisor_reg;
               hit(avReq.address, serial_port_pkg::OFF_RX_DATA):
                  readData_reg[7:0] <= rxData_reg;
               default:
                  readData_reg[7:0] <= serial_port_pkg::RST_BYTE;
            endcase
         end
      end
   end

   // ==========================================================================
   // Control registers
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         rxCtrl_reg <= '0;
         txCtrl_reg <= '0;
         baudDivisor_reg <= serial_port_pkg::RST_BYTE;
         enables_reg <= 2'b00;
         priorities_reg <= 2'b00;
      end else if (clockEnable & writeAccept) begin
         if (hit(avReq.address, serial_port_pkg::OFF_RX_STATUS)) begin
            rxCtrl_reg <= avReq.writedata[7:3];
         end
         if (hit(avReq.address, serial_port_pkg::OFF_TX_STATUS)) begin
            txCtrl_reg <= {avReq.writedata[7:4], avReq.writedata[2], avReq.writedata[0]};
         end
         if (hit(avReq.address, serial_port_pkg::OFF_BAUD_DIV)) begin
            baudDivisor_reg <= avReq.writedata[7:0];
         end
         if (hit(avReq.address, serial_port_pkg::OFF_ENABLES)) begin
            enables_reg <= avReq.writedata[serial_port_pkg::BIT_RX_COMPLETE:serial_port_pkg::BIT_TX_EMPTY];
         end
         if (hit(avReq.address, serial_port_pkg::OFF_PRIORITIES)) begin
            priorities_reg <= avReq.writedata[serial_port_pkg::BIT_RX_COMPLETE:serial_port_pkg::BIT_TX_EMPTY];
         end
      end
   end

   // ==========================================================================
   // Baud generator: x16 sample tick, x64 prescaled by four
   assign brgTick = (baudCount_reg == baudDivisor_reg);
   assign sampleTick = brgTick & (txCtrl_reg.highSpeedBaudSelect |
                                  (prescale_reg == serial_port_pkg::LOW_SPEED_PRESCALE_LAST));

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         baudCount_reg <= serial_port_pkg::RST_BYTE;
         prescale_reg <= 2'b00;
      end else if (clockEnable) begin
         baudCount_reg <= brgTick ? serial_port_pkg::RST_BYTE : baudCount_reg + 8'h01;
         if (brgTick) begin
            prescale_reg <= prescale_reg + 2'b01;
         end
      end
   end

   // ==========================================================================
   // Transmit holding buffer and empty flag
   assign syncMode = rxCtrl_reg.serialPortEnable & txCtrl_reg.syncSelect;
   // Load only once the previous stop bit has left and the shifter is idle
   assign txLoad = holdFull_reg & ~txBusy_reg & txCtrl_reg.transmitEnable &
                   rxCtrl_reg.serialPortEnable & ~(syncMode & (rxState_reg != serial_port_pkg::RX_IDLE));

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         holdData_reg <= serial_port_pkg::RST_BYTE;
         holdFull_reg <= 1'b0;
      end else if (clockEnable) begin
         if (writeAccept & hit(avReq.address, serial_port_pkg::OFF_TX_HOLD)) begin
            holdData_reg <= avReq.writedata[7:0];
            holdFull_reg <= 1'b1;
         end else if (txLoad) begin
            holdFull_reg <= 1'b0;
         end
      end
   end

   // Set wins over clear; a buffer write clears it, as does setting transmit enable with the buffer full
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         txEmptyFlag_reg <= 1'b0;
      end else if (clockEnable) begin
         if (txLoad) begin
            txEmptyFlag_reg <= 1'b1;
         end else if (writeAccept & hit(avReq.address, serial_port_pkg::OFF_TX_STATUS) &
                      avReq.writedata[serial_port_pkg::BIT_TX_ENABLE] & ~txCtrl_reg.transmitEnable) begin
            txEmptyFlag_reg <= ~holdFull_reg;
         end else if (writeAccept & hit(avReq.address, serial_port_pkg::OFF_TX_HOLD)) begin
            txEmptyFlag_reg <= 1'b0;
         end
      end
   end

   // ==========================================================================
   // Transmit shifter, internal only
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         shift_reg <= '1;
         bitsLeft_reg <= 4'h0;
         txTick_reg <= 4'h0;
         txBusy_reg <= 1'b0;
      end else if (clockEnable) begin
         if (txLoad) begin
            if (syncMode) begin
               shift_reg <= {2'b11, txCtrl_reg.transmitNinthBit, holdData_reg};
               bitsLeft_reg <= serial_port_pkg::SYNC_FRAME_BITS + {3'b000, txCtrl_reg.nineBitTransmitEnable};
            end else begin
               shift_reg <= {1'b1, txCtrl_reg.transmitNinthBit, holdData_reg, 1'b0};
               bitsLeft_reg <= serial_port_pkg::ASYNC_FRAME_BITS + {3'b000, txCtrl_reg.nineBitTransmitEnable};
            end
            txTick_reg <= 4'h0;
            txBusy_reg <= 1'b1;
         end else if (txBusy_reg & sampleTick) begin
            txTick_reg <= txTick_reg + 4'h1;
            if (txTick_reg == serial_port_pkg::SAMPLES_LAST) begin
               shift_reg <= {1'b1, shift_reg[10:1]};
               bitsLeft_reg <= bitsLeft_reg - 4'h1;
               if (bitsLeft_reg == 4'h1) begin
                  txBusy_reg <= 1'b0;
               end
               // Nine-bit off: skip ninth slot before stop
               if (~syncMode & ~txCtrl_reg.nineBitTransmitEnable & (bitsLeft_reg == 4'h2)) begin
                  shift_reg <= {2'b11, shift_reg[10:2]};
               end
            end
         end
      end
   end

   // ==========================================================================
   // Pin drivers: async idles high; sync master drives clock and data
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         transmitPin <= 1'b1;
         syncDataOut <= 1'b1;
         syncDataOe_n <= 1'b1;
      end else if (clockEnable) begin
         if (syncMode) begin
            transmitPin <= ~(txBusy_reg & txCtrl_reg.clockSourceSelect & txTick_reg[3]);
            syncDataOut <= shift_reg[0];
            syncDataOe_n <= ~txBusy_reg;
         end else begin
            transmitPin <= txBusy_reg ? shift_reg[0] : 1'b1;
            syncDataOut <= 1'b1;
            syncDataOe_n <= 1'b1;
         end
      end
   end

   // ==========================================================================
   // Receive front end: two-stage sync then x16 sample history
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         rxPinSync_reg <= 2'b11;
         sampleHist_reg <= 3'b111;
      end else if (clockEnable) begin
         rxPinSync_reg <= {rxPinSync_reg[0], receivePin};
         if (sampleTick) begin
            sampleHist_reg <= {sampleHist_reg[1:0], rxPinSync_reg[1]};
         end
      end
   end

   assign sampleBit = majority(sampleHist_reg);
   assign rxEnabled = rxCtrl_reg.serialPortEnable & rxCtrl_reg.continuousReceiveEnable & ~overrunErr_reg &
                      ~syncMode;
   assign rxBitsWanted = rxCtrl_reg.nineBitReceiveEnable ? 4'h9 : 4'h8;
   assign charDone = (rxState_reg == serial_port_pkg::RX_STOP) & sampleTick &
                     (rxTick_reg == serial_port_pkg::SAMPLES_LAST);
   // Address detect drops characters with ninth bit clear
   assign rxTake = charDone & ~(rxCtrl_reg.addressDetectEnable & rxCtrl_reg.nineBitReceiveEnable &
                                ~rxShift_reg[8]);

   // ==========================================================================
   // Receive state machine, one step per x16 sample tick
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         rxState_reg <= serial_port_pkg::RX_IDLE;
         rxTick_reg <= 4'h0;
         rxBitCnt_reg <= 4'h0;
         rxShift_reg <= 9'h000;
      end else if (clockEnable) begin
         if (~rxEnabled) begin
            rxState_reg <= serial_port_pkg::RX_IDLE;
         end else if (sampleTick) begin
            rxTick_reg <= rxTick_reg + 4'h1;
            unique case (rxState_reg)
               serial_port_pkg::RX_IDLE: begin
                  rxTick_reg <= 4'h0;
                  if (~rxPinSync_reg[1]) begin
                     rxState_reg <= serial_port_pkg::RX_START;
                  end
               end
               serial_port_pkg::RX_START: begin
                  if (rxTick_reg == serial_port_pkg::START_CHECK_SAMPLE) begin
                     rxTick_reg <= 4'h0;
                     rxBitCnt_reg <= 4'h0;
                     rxState_reg <= sampleBit ? serial_port_pkg::RX_IDLE : serial_port_pkg::RX_DATA;
                  end
               end
               serial_port_pkg::RX_DATA: begin
                  if (rxTick_reg == serial_port_pkg::SAMPLES_LAST) begin
                     if (rxCtrl_reg.nineBitReceiveEnable) begin
                        rxShift_reg <= {sampleBit, rxShift_reg[8:1]};
                     end else begin
                        rxShift_reg <= {1'b0, sampleBit, rxShift_reg[7:1]};
                     end
                     rxBitCnt_reg <= rxBitCnt_reg + 4'h1;
                     if (rxBitCnt_reg == rxBitsWanted - 4'h1) begin
                        rxState_reg <= serial_port_pkg::RX_STOP;
                     end
                  end
               end
               serial_port_pkg::RX_STOP: begin
                  if (rxTick_reg == serial_port_pkg::SAMPLES_LAST) begin
                     rxState_reg <= serial_port_pkg::RX_IDLE;
                  end
               end
            endcase
         end
      end
   end

   // ==========================================================================
   // Receive buffer, flag and errors
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         rxData_reg <= serial_port_pkg::RST_BYTE;
         rxNinth_reg <= 1'b0;
         rxFull_reg <= 1'b0;
         framingErr_reg <= 1'b0;
         overrunErr_reg <= 1'b0;
      end else if (clockEnable) begin
         if (rxTake & rxFull_reg) begin
            overrunErr_reg <= 1'b1;
         end else if (rxTake) begin
            rxData_reg <= rxShift_reg[7:0];
            rxNinth_reg <= rxShift_reg[8];
            framingErr_reg <= ~sampleBit;
            rxFull_reg <= 1'b1;
         end else if (readAccept & hit(avReq.address, serial_port_pkg::OFF_RX_DATA)) begin
            rxFull_reg <= 1'b0;
         end
         if (~rxCtrl_reg.continuousReceiveEnable) begin
            framingErr_reg <= 1'b0;
            overrunErr_reg <= 1'b0;
         end
      end
   end

   // ==========================================================================
   // Interrupt requests and bus outputs
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         txIrqRequest <= 1'b0;
         rxIrqRequest <= 1'b0;
      end else if (clockEnable) begin
         txIrqRequest <= txEmptyFlag_reg & enables_reg[0];
         rxIrqRequest <= rxFull_reg & enables_reg[1];
      end
   end

   assign avReadData = readData_reg;
   assign avWaitRequest = wait_reg;

endmodule

//--- test/async_serial_transceiver_asserts.sv
// Checker for the serial transceiver: bus handshake, line timing, interrupt gating.
// Assumes it is bound to the top module; shadows follow accepted bus writes.
module async_serial_transceiver_asserts (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic clockEnable,
   input wire serial_port_pkg::av_req_t avReq,
   input wire logic [31:0] avReadData,
   input wire logic avWaitRequest,
   input wire logic transmitPin,
   input wire logic syncDataOut,
   input wire logic syncDataOe_n,
   input wire logic txIrqRequest,
   input wire logic rxIrqRequest
);
   logic [7:0] txShadow_reg;
   logic [7:0] enShadow_reg;
   // =====
   // Shadows of written control bytes
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         txShadow_reg <= 8'h00;
         enShadow_reg <= 8'h00;
      end else if (avReq.write && !avWaitRequest && clockEnable) begin
         if (avReq.address == serial_port_pkg::OFF_TX_STATUS) txShadow_reg <= avReq.writedata[7:0];
         if (avReq.address == serial_port_pkg::OFF_ENABLES) enShadow_reg <= avReq.writedata[7:0];
      end
   end
   // =====
   // Properties
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   sequence s_req; (avReq.read || avReq.write) && avWaitRequest && clockEnable; endsequence
   sequence s_edge; $fell(transmitPin) || $rose(transmitPin); endsequence
   property p_answer; s_req |=> !avWaitRequest; endproperty
   a_answer: assert property (p_answer) else $error("Bus request not answered");
   property p_once; !avWaitRequest && clockEnable |=> avWaitRequest; endproperty
   a_once: assert property (p_once) else $error("Wait low too long");
   property p_idle; avWaitRequest |-> avReadData == 32'h0; endproperty
   a_idle: assert property (p_idle) else $error("Read data outside answer");
   property p_upper; avReadData[31:8] == 24'h0; endproperty
   a_upper: assert property (p_upper) else $error("Upper read bits set");
   property p_unmap; avReq.read && !avWaitRequest && avReq.address[5] |-> avReadData == 32'h0; endproperty
   a_unmap: assert property (p_unmap) else $error("Unmapped read not zero");
   property p_bit;
      s_edge and !txShadow_reg[serial_port_pkg::BIT_SYNC_SELECT] |=> $stable(transmitPin) [*7];
   endproperty
   a_bit: assert property (p_bit) else $error("Line bit too short");
   property p_txIrq; txIrqRequest |-> $past(enShadow_reg[serial_port_pkg::BIT_TX_EMPTY]); endproperty
   a_txIrq: assert property (p_txIrq) else $error("Transmit irq without enable");
   property p_rxIrq; rxIrqRequest |-> $past(enShadow_reg[serial_port_pkg::BIT_RX_COMPLETE]); endproperty
   a_rxIrq: assert property (p_rxIrq) else $error("Receive irq without enable");
   property p_oe; !txShadow_reg[serial_port_pkg::BIT_SYNC_SELECT] |-> syncDataOe_n && syncDataOut; endproperty
   a_oe: assert property (p_oe) else $error("Data line driven in async mode");
endmodule
bind async_serial_transceiver async_serial_transceiver_asserts chk_i (.clock, .sys_rst, .clockEnable, .avReq,
   .avReadData, .avWaitRequest, .transmitPin, .syncDataOut, .syncDataOe_n, .txIrqRequest, .rxIrqRequest);

//--- test/serial_node_model.sv
// Remote serial node: sends frames on the receive pin, decodes the transmit pin.
// Assumes idle-high lines and a bit time of BITCLKS clocks.
module serial_node_model #(parameter int BITCLKS = 16) (
   input wire logic clock,
   input wire logic transmitPin,
   output logic receivePin
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [31:0] got[$];
   int txBits = 9;
   initial receivePin = 1'b1;
   // =====
   // Frame out: start, data, stop, one idle bit
   task automatic sendChar(input logic [8:0] d, input int n, input logic stopV);
      for (int i = 0; i < n + 3; i++) begin
         receivePin <= (i == 0) ? 1'b0 : (i <= n) ? d[i - 1] : (i == n + 1) ? stopV : 1'b1;
         repeat (BITCLKS) @(posedge clock);
      end
   endtask
   // =====
   // Frame in: mid-bit samples after the start edge
   always begin
      logic [31:0] v;
      @(negedge transmitPin);
      v = 32'h0;
      repeat (BITCLKS / 2) @(posedge clock);
      for (int i = 0; i < txBits; i++) begin
         repeat (BITCLKS) @(posedge clock);
         v[i] = transmitPin;
      end
      got.push_back(v);
   end
endmodule

//--- test/async_serial_transceiver_tb.sv
// Self-checking bench for the serial transceiver through its register bus.
// Assumes the node model on the pins and the checker bound to the design.
module async_serial_transceiver_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   serial_port_pkg::av_req_t avReq = '0;
   logic [31:0] avReadData;
   logic [31:0] q;
   logic avWaitRequest, receivePin, transmitPin, txIrq, rxIrq;
   int nErrors = 0;
   int testsRun = 0;
   always #25 clock = ~clock;
   async_serial_transceiver dut (.clock, .sys_rst, .clockEnable(1'b1), .avReq, .avReadData, .avWaitRequest,
      .receivePin, .transmitPin, .syncDataOut(), .syncDataOe_n(), .txIrqRequest(txIrq), .rxIrqRequest(rxIrq));
   serial_node_model #(.BITCLKS(16)) node (.clock, .transmitPin, .receivePin);
   // =====
   // Shared tasks
   task automatic close_out;
      $display("Checks %0d, errors %0d", testsRun, nErrors);
      if (nErrors == 0 && testsRun > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      testsRun++;
      if (seen !== exp) begin
         nErrors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic rd, input logic [5:0] a, input logic [31:0] d);
      avReq <= '{rd, !rd, a, d};
      do begin
         @(posedge clock);
      end while (avWaitRequest !== 1'b0);
      q = avReadData;
      avReq <= '0;
      @(posedge clock);
   endtask
   task automatic rdChk(input logic [5:0] a, input logic [31:0] e);
      bus(1'b1, a, 32'h0);
      chk(q, e);
   endtask
   // =====
   // Scenarios
   task automatic t_regs;
      rdChk(serial_port_pkg::OFF_FLAGS, 32'h0);
      rdChk(serial_port_pkg::OFF_TX_STATUS, 32'h2);
      bus(1'b0, 6'h24, 32'hff);
      rdChk(6'h24, 32'h0);
   endtask
   task automatic t_tx;
      bus(1'b0, serial_port_pkg::OFF_BAUD_DIV, 32'h0);
      bus(1'b0, serial_port_pkg::OFF_RX_STATUS, 32'h80);
      bus(1'b0, serial_port_pkg::OFF_TX_STATUS, 32'h24);
      bus(1'b0, serial_port_pkg::OFF_FLAGS, 32'h0);
      rdChk(serial_port_pkg::OFF_FLAGS, 32'h10);
      bus(1'b0, serial_port_pkg::OFF_ENABLES, 32'h10);
      rdChk(serial_port_pkg::OFF_TX_STATUS, 32'h26);
      chk(txIrq, 1'b1);
      bus(1'b0, serial_port_pkg::OFF_TX_HOLD, 32'ha5);
      bus(1'b0, serial_port_pkg::OFF_TX_HOLD, 32'h3c);
      rdChk(serial_port_pkg::OFF_FLAGS, 32'h0);
      rdChk(serial_port_pkg::OFF_TX_STATUS, 32'h24);
      chk(txIrq, 1'b0);
      while (node.got.size() < 2) @(posedge clock);
      repeat (16) @(posedge clock);
      rdChk(serial_port_pkg::OFF_FLAGS, 32'h10);
      rdChk(serial_port_pkg::OFF_TX_STATUS, 32'h26);
      chk(node.got[0], 32'h1a5);
      chk(node.got[1], 32'h13c);
      node.txBits = 10;
      bus(1'b0, serial_port_pkg::OFF_TX_STATUS, 32'h65);
      bus(1'b0, serial_port_pkg::OFF_TX_HOLD, 32'h5a);
      while (node.got.size() < 3) @(posedge clock);
      chk(node.got[2], 32'h35a);
   endtask
   task automatic t_rx;
      bus(1'b0, serial_port_pkg::OFF_RX_STATUS, 32'h90);
      bus(1'b0, serial_port_pkg::OFF_ENABLES, 32'h30);
      node.sendChar(9'h0c3, 8, 1'b1);
      chk(rxIrq, 1'b1);
      rdChk(serial_port_pkg::OFF_RX_STATUS, 32'h90);
      rdChk(serial_port_pkg::OFF_RX_DATA, 32'hc3);
      rdChk(serial_port_pkg::OFF_FLAGS, 32'h10);
      node.sendChar(9'h055, 8, 1'b0);
      rdChk(serial_port_pkg::OFF_RX_STATUS, 32'h94);
      bus(1'b1, serial_port_pkg::OFF_RX_DATA, 32'h0);
      bus(1'b0, serial_port_pkg::OFF_RX_STATUS, 32'h80);
      rdChk(serial_port_pkg::OFF_RX_STATUS, 32'h80);
      bus(1'b0, serial_port_pkg::OFF_RX_STATUS, 32'h90);
      node.sendChar(9'h011, 8, 1'b1);
      node.sendChar(9'h022, 8, 1'b1);
      rdChk(serial_port_pkg::OFF_RX_STATUS, 32'h92);
      rdChk(serial_port_pkg::OFF_RX_DATA, 32'h11);
      bus(1'b0, serial_port_pkg::OFF_RX_STATUS, 32'h80);
      rdChk(serial_port_pkg::OFF_RX_STATUS, 32'h80);
      bus(1'b0, serial_port_pkg::OFF_RX_STATUS, 32'hd8);
      node.sendChar(9'h011, 9, 1'b1);
      rdChk(serial_port_pkg::OFF_FLAGS, 32'h10);
      node.sendChar(9'h122, 9, 1'b1);
      rdChk(serial_port_pkg::OFF_RX_STATUS, 32'hd9);
      rdChk(serial_port_pkg::OFF_RX_DATA, 32'h22);
      bus(1'b0, serial_port_pkg::OFF_RX_STATUS, 32'hd0);
      node.sendChar(9'h033, 9, 1'b1);
      rdChk(serial_port_pkg::OFF_RX_DATA, 32'h33);
   endtask
   // =====
   // Main sequence and watchdog
   initial begin
      repeat (6) @(posedge clock);
      sys_rst <= 1'b0;
      @(posedge clock);
      t_regs();
      t_tx();
      t_rx();
      close_out();
   end
   initial begin
      repeat (20000) @(posedge clock);
      nErrors++;
      close_out();
   end
endmodule
